// ---- hdl/lbs_pkg.sv ----
// lbs_pkg: constants for the lock based output source switch
// assumes a single 100 MHz aclk and a 32-bit AXI4-Lite register bus
package lbs_pkg;

  // ----------------------------------------------------------------
  // clocking
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 10.0;
  // reference clock that the board must supply
  localparam real REF_CLK_MHZ = 24.576;
  // free-running pll clock kept on the master clock after lock loss
  localparam real HOLDOVER_MS = 2.7;
  localparam int HOLDOVER_CYCLES = int'(HOLDOVER_MS * 1.0e6 / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;

  // control fields
  localparam int CTRL_W = 3;
  localparam int CTRL_AMP_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_RATE_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

  // status fields
  localparam int ST_LOCK_BIT = 0;
  localparam int ST_CLKPLL_BIT = 1;
  localparam int ST_HOLD_BIT = 2;
  localparam int ST_AMP_BIT = 3;
  localparam int ST_DIR_BIT = 4;
  localparam int ST_MPIN_BIT = 5;
  localparam int ST_AUX_BIT = 6;
  localparam int ST_DRVLOW_BIT = 7;
  localparam int ST_LEVEL_LSB = 8;

  // ----------------------------------------------------------------
  // bus answers and data formats
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [1:0] FMT_I2S = 2'h0;

  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 8;

endpackage : lbs_pkg

// ---- hdl/lbs_fifo.sv ----
// lbs_fifo: flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module lbs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } lbs_fifo_s;

  lbs_fifo_s st;
  lbs_fifo_s next_st;
  logic push;
  logic pop;

  assign in_ready = (st.count != FULL);
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd];
  assign level = st.count;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == LAST) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == LAST) ? '0 : st.rd + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : lbs_fifo

// ---- hdl/lbs_switch.sv ----
// lbs_switch: output source control of a digital audio receiver
// assumes pll lock, receive activity and emphasis come from other clocks
// and are synchronised here; registers sit on AXI4-Lite
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/10ps
module lbs_switch
  import lbs_pkg::*;
#(
  parameter int HOLD_CYCLES = lbs_pkg::HOLDOVER_CYCLES,
  parameter int WIDTH = lbs_pkg::DATA_W,
  parameter int DEPTH = lbs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [lbs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [lbs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // receiver status from other domains
  input wire logic pll_lock_async,
  input wire logic rx_active_async,
  input wire logic emphasis_async,
  // multi-purpose pin
  input wire logic multi_purpose_pin_i,
  output logic multi_purpose_pin_o,
  output logic multi_purpose_pin_oe,
  output logic second_rx_input,
  // clock source control
  output logic clk_src_pll,
  output logic clk_holdover,
  output logic unlocked_clock_rate_select,
  output logic osc_amp_enable,
  output logic fs_track_enable,
  // demodulated data stream
  input wire logic demod_valid,
  input wire logic [WIDTH-1:0] demod_data,
  output logic demod_ready,
  // auxiliary serial input stream
  input wire logic aux_valid,
  input wire logic [WIDTH-1:0] aux_data,
  output logic aux_ready,
  // serial data output stream
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [1:0] out_format
);
  localparam int HCW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HCW-1:0] HOLD_LOAD = HCW'(HOLD_CYCLES - 1);
  localparam int LW = $clog2(DEPTH) + 1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lock_s1;
    logic lock_s2;
    logic act_s1;
    logic act_s2;
    logic emph_s1;
    logic emph_s2;
    logic mp_s1;
    logic mp_s2;
    logic locked;
    logic amp_keep;
    logic [CTRL_W-1:0] ctrl;
    logic holdover;
    logic [HCW-1:0] hold_cnt;
    logic drive_low;
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } lbs_state_s;

  lbs_state_s st;
  lbs_state_s next_st;

  logic fifo_in_valid;
  logic [WIDTH-1:0] fifo_in_data;
  logic fifo_in_ready;
  logic [LW-1:0] fifo_level;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // data path
  // ----------------------------------------------------------------
  // unselected source is stalled, selected one sees fifo back-pressure
  assign fifo_in_valid = st.locked ? demod_valid : aux_valid;
  assign fifo_in_data = st.locked ? demod_data : aux_data;
  assign demod_ready = st.locked && fifo_in_ready;
  assign aux_ready = !st.locked && fifo_in_ready;
  assign out_format = FMT_I2S;

  lbs_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(out_valid),
    .out_data(out_data),
    .out_ready(out_ready),
    .level(fifo_level)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // master clock stays on pll during holdover so the edge is continuous
  assign clk_src_pll = st.locked || st.holdover;
  assign clk_holdover = st.holdover;
  assign unlocked_clock_rate_select = st.ctrl[CTRL_RATE_BIT];
  assign osc_amp_enable = st.amp_keep || !st.locked;
  assign fs_track_enable = st.amp_keep || !st.locked;
  // open drain: only ever pulls low
  assign multi_purpose_pin_o = 1'b0;
  assign multi_purpose_pin_oe = st.drive_low;
  assign second_rx_input = st.ctrl[CTRL_DIR_BIT] && st.mp_s2;

  assign s_axi_awready = !st.aw_held && !st.bvalid;
  assign s_axi_wready = !st.w_held && !st.bvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  always_comb begin
    status_word = WORD_ZERO;
    status_word[ST_LOCK_BIT] = st.locked;
    status_word[ST_CLKPLL_BIT] = st.locked || st.holdover;
    status_word[ST_HOLD_BIT] = st.holdover;
    status_word[ST_AMP_BIT] = st.amp_keep || !st.locked;
    status_word[ST_DIR_BIT] = st.ctrl[CTRL_DIR_BIT];
    status_word[ST_MPIN_BIT] = st.mp_s2;
    status_word[ST_AUX_BIT] = !st.locked;
    status_word[ST_DRVLOW_BIT] = st.drive_low;
    status_word[ST_LEVEL_LSB +: LW] = fifo_level;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // two-flop synchronisers
    next_st.lock_s1 = pll_lock_async;
    next_st.lock_s2 = st.lock_s1;
    next_st.act_s1 = rx_active_async;
    next_st.act_s2 = st.act_s1;
    next_st.emph_s1 = emphasis_async;
    next_st.emph_s2 = st.emph_s1;
    next_st.mp_s1 = multi_purpose_pin_i;
    next_st.mp_s2 = st.mp_s1;

    // single lock indicator for clocks and data
    next_st.locked = st.lock_s2;

    // holdover on lock loss, cleared by relock or when hold_cnt runs out
    if (st.locked && !st.lock_s2) begin
      next_st.holdover = 1'b1;
      next_st.hold_cnt = HOLD_LOAD;
    end else if (st.lock_s2) begin
      next_st.holdover = 1'b0;
      next_st.hold_cnt = '0;
    end else if (st.holdover) begin
      if (st.hold_cnt == '0) begin
        next_st.holdover = 1'b0;
      end else begin
        next_st.hold_cnt = st.hold_cnt - 1'b1;
      end
    end

    // keep-running setting is only taken in while unlocked and acts once locked
    if (!st.locked) begin
      next_st.amp_keep = st.ctrl[CTRL_AMP_BIT];
    end

    // emphasis flag pulls low only as output with live data
    next_st.drive_low = !st.ctrl[CTRL_DIR_BIT] && st.act_s2 && st.emph_s2;

    // write channels, taken in either order
    if (s_axi_awvalid && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held && !st.bvalid) begin
      next_st.w_held = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb0 = s_axi_wstrb[0];
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      if (st.aw_addr == ADDR_CTRL) begin
        next_st.bresp = RESP_OKAY;
        if (st.w_strb0) begin
          next_st.ctrl = st.w_data[CTRL_W-1:0];
        end
      end else if (st.aw_addr == ADDR_STATUS) begin
        next_st.bresp = RESP_OKAY;
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    // read channel
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      if (s_axi_araddr == ADDR_CTRL) begin
        next_st.rdata = {{(32-CTRL_W){1'b0}}, st.ctrl};
        next_st.rresp = RESP_OKAY;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        next_st.rdata = status_word;
        next_st.rresp = RESP_OKAY;
      end else begin
        next_st.rdata = WORD_ZERO;
        next_st.rresp = RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.ctrl <= CTRL_RESET;
      st.bresp <= RESP_OKAY;
      st.rresp <= RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

endmodule : lbs_switch

// ---- verification/lbs_switch_properties.sv ----
// lbs_switch_properties: port-level checks of the source switch
// assumes binding onto every lbs_switch, hold count handed on
`timescale 1ns/10ps
module lbs_switch_properties #(
  parameter int HOLD_CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus and status inputs
  input wire logic s_axi_bvalid,
  input wire logic rx_active_async,
  input wire logic emphasis_async,
  // pin
  input wire logic multi_purpose_pin_o,
  input wire logic multi_purpose_pin_oe,
  input wire logic second_rx_input,
  // clock control
  input wire logic clk_src_pll,
  input wire logic clk_holdover,
  input wire logic unlocked_clock_rate_select,
  input wire logic osc_amp_enable,
  input wire logic fs_track_enable,
  // streams
  input wire logic demod_ready,
  input wire logic aux_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [31:0] out_data,
  input wire logic [1:0] out_format
);
  import lbs_pkg::*;
  logic locked;
  logic [31:0] hold_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign locked = clk_src_pll && !clk_holdover;
  always_ff @(posedge aclk) begin
    if (!aresetn || !clk_holdover) begin
      hold_cnt <= 32'h0000_0000;
    end else begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
    end
  end
  amp_stop_a: assert property (!osc_amp_enable |-> locked)
    else $error("amplifier stopped while unlocked");
  amp_track_a: assert property (osc_amp_enable == fs_track_enable)
    else $error("rate tracking differs from amplifier");
  amp_freeze_a: assert property (locked && $past(locked) |-> $stable(osc_amp_enable))
    else $error("amplifier changed while locked");
  src_aux_a: assert property (aux_ready |-> !locked)
    else $error("aux taken while locked");
  src_demod_a: assert property (demod_ready |-> locked)
    else $error("demod taken while unlocked");
  clk_rise_a: assert property ($rose(clk_src_pll) |-> locked)
    else $error("pll clock chosen without lock");
  clk_glitch_a: assert property ($fell(clk_src_pll) |-> $past(clk_holdover))
    else $error("pll clock dropped without holdover");
  hold_len_a: assert property ($fell(clk_holdover) && !clk_src_pll |-> hold_cnt == HOLD_CYCLES)
    else $error("holdover length wrong");
  emph_pull_a: assert property ($rose(multi_purpose_pin_oe)
    |-> $past(rx_active_async, 3) && $past(emphasis_async, 3))
    else $error("pin pulled without emphasis");
  pin_od_a: assert property (!multi_purpose_pin_o && !(multi_purpose_pin_oe && second_rx_input))
    else $error("pin drive wrong");
  rate_wr_a: assert property ($changed(unlocked_clock_rate_select) |-> $rose(s_axi_bvalid))
    else $error("rate select moved without write");
  fmt_a: assert property (out_format == FMT_I2S)
    else $error("output format not default");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word not held");
endmodule : lbs_switch_properties

bind lbs_switch lbs_switch_properties #(.HOLD_CYCLES(HOLD_CYCLES)) i_lbs_switch_properties (.*);

// ---- verification/lbs_far_end.sv ----
// lbs_far_end: receiver front end sources and converter-side sink
// assumes reset low at start; run gates sources, stall holds the sink
`timescale 1ns/10ps
module lbs_far_end (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // mode
  input wire logic run,
  input wire logic stall,
  // sources
  output logic demod_valid,
  output logic [31:0] demod_data,
  input wire logic demod_ready,
  output logic aux_valid,
  output logic [31:0] aux_data,
  input wire logic aux_ready,
  // sink, a slave taking the block's clocks
  output logic out_ready
);
  int seed = 52;
  always @(posedge aclk) begin
    if (!aresetn) begin
      demod_valid <= 1'h0;
      demod_data <= 32'h0000_0000;
      aux_valid <= 1'h0;
      aux_data <= 32'h0000_0000;
      out_ready <= 1'h0;
    end else begin
      // hold a word until taken, else a fresh one offered on about three cycles in four
      if (!demod_valid || demod_ready) begin
        demod_valid <= run && ($random(seed) % 4 != 0);
        demod_data <= $random(seed);
      end
      // same framing as demodulated words
      if (!aux_valid || aux_ready) begin
        aux_valid <= run && ($random(seed) % 4 != 0);
        aux_data <= $random(seed);
      end
      out_ready <= !stall && ($random(seed) % 4 != 0);
    end
  end
endmodule : lbs_far_end

// ---- verification/lbs_switch_bench.sv ----
// lbs_switch_bench: self-checking bench of the source switch
// assumes lbs_switch, lbs_far_end and the bound checker are compiled
`timescale 1ns/10ps
module lbs_switch_bench;
  import lbs_pkg::*;
  typedef struct {logic [31:0] e, m; logic [1:0] r;} lbs_rd_s;
  logic aclk = 1'h0, aresetn = 1'h0, run = 1'h0, stall = 1'h0, pin_ext = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, out_data, demod_data, aux_data;
  logic pll_lock_async = 1'h0, rx_active_async = 1'h0, emphasis_async = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic multi_purpose_pin_i, multi_purpose_pin_o, multi_purpose_pin_oe, second_rx_input;
  logic clk_src_pll, clk_holdover, unlocked_clock_rate_select, osc_amp_enable;
  logic fs_track_enable, demod_valid, demod_ready, aux_valid, aux_ready, out_valid, out_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp, out_format;
  lbs_rd_s rq[$];
  logic [1:0] bq[$];
  logic [31:0] sq[$];
  int mismatches = 0, checks_done = 0;
  // open-drain pin with pull-up
  assign multi_purpose_pin_i = multi_purpose_pin_oe ? 1'h0 : pin_ext;
  lbs_switch #(.HOLD_CYCLES(20)) i_lbs_switch (.*);
  lbs_far_end i_lbs_far_end (.*);
  always #5 aclk = ~aclk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp(32'(got), 32'(exp));
  endtask : cmp_resp
  task automatic cmp_rdata(input logic [31:0] got, exp, m);
    cmp(got & m, exp);
  endtask : cmp_rdata
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask : cmp_word
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e, m, input logic [1:0] r);
    rq.push_back('{e, m, r});
    @(posedge aclk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    lbs_rd_s n;
    if (s_axi_bvalid && s_axi_bready) cmp_resp(s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      n = rq.pop_front();
      cmp_rdata(s_axi_rdata, n.e, n.m);
      cmp_resp(s_axi_rresp, n.r);
    end
    if (out_valid && out_ready) cmp_word(out_data, sq.pop_front());
    if (aux_valid && aux_ready) sq.push_back(aux_data);
    if (demod_valid && demod_ready) sq.push_back(demod_data);
  end
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    test_done;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    rd(ADDR_CTRL, 32'h0000_0000, 32'h0000_0007, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0000_0068, 32'h0000_0fff, RESP_OKAY);
    wr(4'h8, 32'h0000_0007, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
    rd(4'hc, 32'h0000_0000, 32'hffff_ffff, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_CTRL, 32'(i), RESP_OKAY);
      rd(ADDR_CTRL, 32'(i), 32'h0000_0007, RESP_OKAY);
      cmp(32'(unlocked_clock_rate_select), 32'(i[2]));
      cmp(32'(osc_amp_enable), 32'h0000_0001);
    end
    s_axi_wstrb <= 4'h0;
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_CTRL, 32'h0000_0007, 32'h0000_0007, RESP_OKAY);
    pin_ext <= 1'h0;
    rx_active_async <= 1'h1;
    emphasis_async <= 1'h1;
    repeat (6) @(posedge aclk);
    cmp(32'(second_rx_input), 32'h0000_0000);
    cmp(32'(multi_purpose_pin_oe), 32'h0000_0000);
    pin_ext <= 1'h1;
    rx_active_async <= 1'h0;
    repeat (6) @(posedge aclk);
    cmp(32'(second_rx_input), 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
    rx_active_async <= 1'h1;
    repeat (6) @(posedge aclk);
    cmp(32'(multi_purpose_pin_oe), 32'h0000_0001);
    emphasis_async <= 1'h0;
    repeat (6) @(posedge aclk);
    cmp(32'(multi_purpose_pin_oe), 32'h0000_0000);
    rx_active_async <= 1'h0;
    run <= 1'h1;
    stall <= 1'h1;
    repeat (30) @(posedge aclk);
    cmp(32'(aux_ready), 32'h0000_0000);
    rd(ADDR_STATUS, 32'h0000_0800, 32'h0000_0f00, RESP_OKAY);
    stall <= 1'h0;
    repeat (40) @(posedge aclk);
    pll_lock_async <= 1'h1;
    repeat (60) @(posedge aclk);
    cmp(32'(clk_src_pll), 32'h0000_0001);
    cmp(32'(osc_amp_enable), 32'h0000_0000);
    cmp(32'(aux_ready), 32'h0000_0000);
    wr(ADDR_CTRL, 32'h0000_0001, RESP_OKAY);
    cmp(32'(osc_amp_enable), 32'h0000_0000);
    pll_lock_async <= 1'h0;
    repeat (6) @(posedge aclk);
    cmp(32'(clk_src_pll), 32'h0000_0001);
    cmp(32'(demod_ready), 32'h0000_0000);
    repeat (40) @(posedge aclk);
    cmp(32'(clk_src_pll), 32'h0000_0000);
    pll_lock_async <= 1'h1;
    repeat (10) @(posedge aclk);
    cmp(32'(osc_amp_enable), 32'h0000_0001);
    cmp(32'(fs_track_enable), 32'h0000_0001);
    pll_lock_async <= 1'h0;
    run <= 1'h0;
    repeat (40) @(posedge aclk);
    rd(ADDR_STATUS, 32'h0000_0000, 32'h0000_0f00, RESP_OKAY);
    cmp(32'(sq.size()), 32'h0000_0000);
    test_done;
  end
endmodule : lbs_switch_bench
